// file: rtl/spm_cfg.svh
// constants for the strap-selected multi-use pin function mux
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH
`define SPM_STRAP_W 3
`define SPM_STRAP_MIXED 3'h0
`define SPM_STRAP_SWAP 3'h1
`define SPM_STRAP_SPEED 3'h2
`define SPM_STRAP_GPIO 3'h3
`define SPM_STRAP_BCIND 3'h4
`define SPM_STRAP_UART 3'h5
`define SPM_SAMPLE_DELAY 2'h2
`define SPM_ADDR_W 7
`endif

// file: rtl/spm_pin_mux.sv
// strap-selected function mux for the seven multi-use pins
`timescale 1ns/1ps
`default_nettype none
`include "spm_cfg.svh"
module spm_pin_mux #(
	parameter int ADDR_W = `SPM_ADDR_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// decoded mode-select strap level
	input wire logic [2:0] mode_strap_code,
	input wire logic serial_iface_strap_sel,
	// multi-use pins
	input wire logic [7:1] multi_use_pin_in,
	output logic [7:1] multi_use_pin_out,
	output logic [7:1] multi_use_pin_oe,
	// general I/O user side
	input wire logic [3:1] general_io_wr,
	input wire logic [3:1] general_io_dir,
	output logic [3:1] general_io_rd,
	// management interface core side
	input wire logic mgmt_data_drive_low,
	input wire logic mgmt_clock_drive_low,
	output logic mgmt_data_pin,
	output logic mgmt_clock_pin,
	output logic mgmt_iface_en,
	output logic mgmt_bridge_mode,
	// hub state
	input wire logic hs_suspend,
	input wire logic [ADDR_W-1:0] hs_addr_p0,
	input wire logic [ADDR_W-1:0] ss_addr_p0,
	input wire logic [ADDR_W-1:0] hs_addr_p1,
	input wire logic [ADDR_W-1:0] ss_addr_p1,
	// role swap and active configuration
	output logic role_swap_request,
	output logic [2:0] active_cfg
);
	// host detection compares whole address fields; wider fields are not served
	if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
		$error("spm_pin_mux: ADDR_W out of range");
	end

	////////////////////////////////////////////////////////////////////
	// input synchronisers: pins and strap are asynchronous to sys_clk
	// reset clears both stages so the strap capture never sees a stale level
	logic [7:1] pin_s1;
	logic [7:1] pin_s2;
	logic [2:0] strap_s1;
	logic [2:0] strap_s2;
	logic sel_s1;
	logic sel_s2;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_s1 <= 7'h00;
			pin_s2 <= 7'h00;
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
		end else begin
			pin_s1 <= multi_use_pin_in;
			pin_s2 <= pin_s1;
			strap_s1 <= mode_strap_code;
			strap_s2 <= strap_s1;
			sel_s1 <= serial_iface_strap_sel;
			sel_s2 <= sel_s1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// strap capture: wait for the synchroniser to fill, then latch once
	logic [1:0] wait_cnt;
	logic [1:0] next_wait_cnt;
	logic latched;
	logic next_latched;
	spm_pkg::spm_cfg_t cfg;
	spm_pkg::spm_cfg_t next_cfg;
	logic bridge;
	logic next_bridge;
	always_comb begin
		next_wait_cnt = wait_cnt;
		next_latched = latched;
		next_cfg = cfg;
		next_bridge = bridge;
		if (!latched) begin
			if (wait_cnt == `SPM_SAMPLE_DELAY) begin
				next_latched = 1'b1;
				next_bridge = sel_s2;
				case (strap_s2)
					`SPM_STRAP_SWAP: next_cfg = spm_pkg::SPM_CFG_SWAP;
					`SPM_STRAP_SPEED: next_cfg = spm_pkg::SPM_CFG_SPEED;
					`SPM_STRAP_GPIO: next_cfg = spm_pkg::SPM_CFG_GPIO;
					`SPM_STRAP_BCIND: next_cfg = spm_pkg::SPM_CFG_BCIND;
					`SPM_STRAP_UART: next_cfg = spm_pkg::SPM_CFG_UART;
					default: next_cfg = spm_pkg::SPM_CFG_MIXED;
				endcase
			end else begin
				next_wait_cnt = wait_cnt + 2'h1;
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wait_cnt <= 2'h0;
			latched <= 1'b0;
			cfg <= spm_pkg::SPM_CFG_MIXED;
			bridge <= 1'b0;
		end else begin
			wait_cnt <= next_wait_cnt;
			latched <= next_latched;
			cfg <= next_cfg;
			bridge <= next_bridge;
		end
	end

	////////////////////////////////////////////////////////////////////
	// host detection per port
	logic [1:0] host_seen;
	logic [1:0] host_slow;
	always_comb begin
		host_seen[0] = (ss_addr_p0 != '0) || (hs_addr_p0 != '0);
		host_seen[1] = (ss_addr_p1 != '0) || (hs_addr_p1 != '0);
		// a fast-class address wins if both are set
		host_slow[0] = (ss_addr_p0 == '0);
		host_slow[1] = (ss_addr_p1 == '0);
	end

	////////////////////////////////////////////////////////////////////
	// pin function selection
	spm_pkg::spm_pins_t pins;
	spm_pkg::spm_pins_t next_pins;
	logic swap;
	logic next_swap;
	logic [3:1] gio_rd;
	logic [3:1] next_gio_rd;
	logic mdat;
	logic mclk;
	logic next_mdat;
	logic next_mclk;
	logic men;
	logic next_men;
	spm_pkg::spm_gio_t gio;
	always_comb begin
		gio.out = general_io_wr;
		gio.oe = general_io_dir;
		next_pins.out = 7'h00;
		next_pins.oe = 7'h00;
		next_swap = swap;
		next_gio_rd = gio_rd;
		next_men = 1'b0;
		next_mdat = 1'b1;
		next_mclk = 1'b1;
		if (latched) begin
			// pins 4 and 5 open drain; unusable in gpio and bc indicator modes
			next_men = (cfg != spm_pkg::SPM_CFG_GPIO) && (cfg != spm_pkg::SPM_CFG_BCIND);
			if (next_men) begin
				next_pins.oe[4] = mgmt_data_drive_low;
				next_pins.oe[5] = mgmt_clock_drive_low;
				next_mdat = pin_s2[4];
				next_mclk = pin_s2[5];
			end
			unique case (cfg)
				spm_pkg::SPM_CFG_MIXED: begin
					next_pins.out[3:1] = gio.out;
					next_pins.oe[3:1] = gio.oe;
					next_gio_rd = pin_s2[3:1];
					next_swap = pin_s2[6];
					next_pins.out[7] = hs_suspend;
					next_pins.oe[7] = 1'b1;
				end
				spm_pkg::SPM_CFG_SWAP: begin
					next_swap = pin_s2[6];
					next_pins.out[1] = host_slow[0];
					next_pins.oe[1] = host_seen[0];
					next_pins.out[2] = host_slow[1];
					next_pins.oe[2] = host_seen[1];
					// both taken from next_swap in one cycle
					next_pins.out[7] = next_swap;
					next_pins.out[3] = ~next_swap;
					next_pins.oe[7] = 1'b1;
					next_pins.oe[3] = 1'b1;
				end
				// other configurations drive nothing here and clear swap; pins 1-3, 6 and 7 float
				spm_pkg::SPM_CFG_SPEED, spm_pkg::SPM_CFG_GPIO,
				spm_pkg::SPM_CFG_BCIND, spm_pkg::SPM_CFG_UART: begin
					next_swap = 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pins <= '0;
			swap <= 1'b0;
			gio_rd <= 3'h0;
			mdat <= 1'b1;
			mclk <= 1'b1;
			men <= 1'b0;
		end else begin
			pins <= next_pins;
			swap <= next_swap;
			gio_rd <= next_gio_rd;
			mdat <= next_mdat;
			mclk <= next_mclk;
			men <= next_men;
		end
	end

	assign multi_use_pin_out = pins.out;
	assign multi_use_pin_oe = pins.oe;
	assign general_io_rd = gio_rd;
	assign mgmt_data_pin = mdat;
	assign mgmt_clock_pin = mclk;
	assign mgmt_iface_en = men;
	assign mgmt_bridge_mode = bridge;
	assign role_swap_request = swap;
	assign active_cfg = cfg;

	////////////////////////////////////////////////////////////////////
	// checks
	a_swap_pair_differ: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP && pins.oe[7])
		|-> (pins.out[7] != pins.out[3])) else $error("swap outputs equal");
	a_swap_true_follow: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP) |=> (pins.out[7] == swap))
		else $error("swap state not on pin seven");
	a_swap_compl_follow: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP) |=> (pins.out[3] == !swap && pins.oe[3]))
		else $error("complement not on pin three");
	a_swap_oe: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP) |=> (pins.oe[7] && pins.oe[3] && !pins.oe[6]))
		else $error("swap pin enables wrong");
	a_cfg_held: assert property (@(posedge sys_clk) disable iff (srst)
		latched |=> ($stable(cfg) && latched)) else $error("configuration changed");
	a_latch_time: assert property (@(posedge sys_clk)
		$fell(srst) |-> !latched [*3] ##1 latched) else $error("strap latch timing");
	a_unused_float: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg != spm_pkg::SPM_CFG_MIXED && cfg != spm_pkg::SPM_CFG_SWAP)
		|=> (pins.oe[3:1] == 3'h0 && pins.oe[7:6] == 2'h0 && !swap))
		else $error("unused configuration drives pins");
	a_mixed_susp: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_MIXED)
		|=> (pins.oe[7] && pins.out[7] == $past(hs_suspend))) else $error("suspend flag not driven");
	a_mixed_gio: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_MIXED) |=> (pins.oe[3:1] == $past(general_io_dir)))
		else $error("general io enable wrong");
	a_gio_read: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_MIXED) |=> (gio_rd == $past(pin_s2[3:1])))
		else $error("general io read wrong");
	// host kind: none, fast and slow cases for each port
	a_host_none_z: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP && hs_addr_p0 == '0 && ss_addr_p0 == '0)
		|=> !pins.oe[1]) else $error("port0 kind driven without host");
	a_host_fast_p0: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP && ss_addr_p0 != '0)
		|=> (pins.oe[1] && !pins.out[1])) else $error("port0 fast host not low");
	a_host_slow_p0: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP && ss_addr_p0 == '0 && hs_addr_p0 != '0)
		|=> (pins.oe[1] && pins.out[1])) else $error("port0 slow host not high");
	a_host_fast_low: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP && ss_addr_p1 != '0)
		|=> (pins.oe[2] && !pins.out[2])) else $error("port1 fast host not low");
	a_host_slow_p1: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP && ss_addr_p1 == '0 && hs_addr_p1 != '0)
		|=> (pins.oe[2] && pins.out[2])) else $error("port1 slow host not high");
	a_host_none_p1: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_SWAP && hs_addr_p1 == '0 && ss_addr_p1 == '0)
		|=> !pins.oe[2]) else $error("port1 kind driven without host");
	a_mgmt_od: assert property (@(posedge sys_clk) disable iff (srst)
		!pins.out[4] && !pins.out[5]) else $error("management pin driven high");
	a_mgmt_drive_low: assert property (@(posedge sys_clk) disable iff (srst)
		men |-> (pins.oe[4] == $past(mgmt_data_drive_low)
			&& pins.oe[5] == $past(mgmt_clock_drive_low))) else $error("management pull-down wrong");
	a_mgmt_idle_high: assert property (@(posedge sys_clk) disable iff (srst)
		!men |-> (mdat && mclk && pins.oe[5:4] == 2'h0))
		else $error("disabled management pins not idle");
	a_bridge_latch: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(latched) |-> (bridge == $past(sel_s2))) else $error("bridge mode not latched");
	a_mgmt_off: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && (cfg == spm_pkg::SPM_CFG_GPIO || cfg == spm_pkg::SPM_CFG_BCIND))
		|=> !men) else $error("management enabled in unusable mode");
	a_swap_input: assert property (@(posedge sys_clk) disable iff (srst)
		(latched && cfg == spm_pkg::SPM_CFG_MIXED) |=> (swap == $past(pin_s2[6])))
		else $error("swap request not taken");
endmodule : spm_pin_mux
`default_nettype wire

// file: rtl/spm_pkg.sv
// types shared by the multi-use pin function mux
package spm_pkg;
	typedef enum logic [2:0] {
		SPM_CFG_MIXED = 3'h0,
		SPM_CFG_SWAP = 3'h1,
		SPM_CFG_SPEED = 3'h2,
		SPM_CFG_GPIO = 3'h3,
		SPM_CFG_BCIND = 3'h4,
		SPM_CFG_UART = 3'h5
	} spm_cfg_t;
	typedef struct packed {
		logic [7:1] out;
		logic [7:1] oe;
	} spm_pins_t;
	typedef struct packed {
		logic [3:1] out;
		logic [3:1] oe;
	} spm_gio_t;
endpackage : spm_pkg

// file: testbench/spm_board_model.sv
// board side of the multi-use pins: pull-ups, swap request, general I/O drive
`timescale 1ns/1ps
`default_nettype none
module spm_board_model (
	// design pin drive
	input wire logic [7:1] pin_out,
	input wire logic [7:1] pin_oe,
	// board stimulus
	input wire logic [3:1] gio_drv,
	input wire logic swap_drv,
	// resolved pin levels
	output logic [7:1] pin_lvl
);
	always_comb begin
		pin_lvl[3:1] = (pin_oe[3:1] & pin_out[3:1]) | (~pin_oe[3:1] & gio_drv);
		pin_lvl[5:4] = ~(pin_oe[5:4] & ~pin_out[5:4]);
		pin_lvl[6] = swap_drv;
		// a floating pin shows the inverse so a stale value cannot pass
		pin_lvl[7] = pin_oe[7] ? pin_out[7] : ~pin_out[7];
	end
endmodule : spm_board_model
`default_nettype wire

// file: testbench/tb_spm_pin_mux.sv
// self-checking testbench for the multi-use pin function mux
`timescale 1ns/1ps
`default_nettype none
module tb_spm_pin_mux;
	typedef struct {int cyc; int s; logic [6:0] m; logic [6:0] e; string nm;} spm_note_t;
	logic sys_clk = 1'b0, srst = 1'b1, sel = 1'b0, hs_susp = 1'b0;
	logic dlow = 1'b0, clow = 1'b0, swp = 1'b0;
	logic [2:0] strap = 3'h0;
	logic [3:1] wr = 3'h0, dir = 3'h0, gdrv = 3'h0, grd;
	logic [6:0] a0h = 7'h00, a0s = 7'h00, a1h = 7'h00, a1s = 7'h00;
	logic [7:1] pout, poe, plvl;
	logic mdat, mclk, men, mbr, rsw;
	logic [2:0] acfg;
	logic [31:0] lf = 32'h5199F557;
	int pc = 0, n_fail = 0, num_checks = 0;
	spm_note_t q[$];
	spm_pin_mux #(.ADDR_W(7)) u_dut (.sys_clk(sys_clk), .srst(srst),
		.mode_strap_code(strap), .serial_iface_strap_sel(sel),
		.multi_use_pin_in(plvl), .multi_use_pin_out(pout), .multi_use_pin_oe(poe),
		.general_io_wr(wr), .general_io_dir(dir), .general_io_rd(grd),
		.mgmt_data_drive_low(dlow), .mgmt_clock_drive_low(clow),
		.mgmt_data_pin(mdat), .mgmt_clock_pin(mclk), .mgmt_iface_en(men),
		.mgmt_bridge_mode(mbr), .hs_suspend(hs_susp), .hs_addr_p0(a0h),
		.ss_addr_p0(a0s), .hs_addr_p1(a1h), .ss_addr_p1(a1s),
		.role_swap_request(rsw), .active_cfg(acfg));
	spm_board_model u_board (.pin_out(pout), .pin_oe(poe), .gio_drv(gdrv),
		.swap_drv(swp), .pin_lvl(plvl));
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) pc <= pc + 1;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic logic [6:0] pick(input int s);
		case (s)
			0: return pout;
			1: return poe;
			2: return {4'h0, grd};
			3: return {5'h0, mdat, mclk};
			4: return {6'h0, men};
			5: return {6'h0, mbr};
			6: return {6'h0, rsw};
			default: return {4'h0, acfg};
		endcase
	endfunction : pick
	task automatic note(input int d, s, input logic [6:0] m, e, input string nm);
		q.push_back('{pc + d, s, m, e & m, nm});
	endtask : note
	task automatic check(input string nm, input logic [6:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : check
	// results are levels, so each note is judged once its settling edge has passed
	always @(negedge sys_clk) begin
		while (q.size() > 0 && q[0].cyc <= pc) begin
			check(q[0].nm, pick(q[0].s) & q[0].m, q[0].e);
			void'(q.pop_front());
		end
	end
	task automatic print_verdict();
		// a note still waiting means a result was never looked at
		if (q.size() > 0) begin
			n_fail++;
		end
		if (n_fail == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	task automatic boot(input logic [2:0] s);
		@(negedge sys_clk);
		srst = 1'b1;
		strap = s;
		lf = lfsr(lf);
		sel = lf[0];
		repeat (4) @(negedge sys_clk);
		srst = 1'b0;
		repeat (5) @(negedge sys_clk);
		note(1, 7, 7'h07, {4'h0, s}, "active_cfg");
		note(1, 4, 7'h01, {6'h0, (s != 3'h3 && s != 3'h4)}, "mgmt_iface_en");
		note(1, 5, 7'h01, {6'h0, sel}, "mgmt_bridge_mode");
		strap = ~s;
		repeat (6) @(negedge sys_clk);
		note(1, 7, 7'h07, {4'h0, s}, "held active_cfg");
		repeat (2) @(negedge sys_clk);
	endtask : boot
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		boot(3'h0);
		repeat (8) begin
			lf = lfsr(lf);
			{wr, dir, gdrv, hs_susp, dlow, clow, swp} = lf[12:0];
			note(1, 1, 7'h7F, {2'h2, clow, dlow, dir}, "pin oe");
			note(1, 0, {2'h2, clow, dlow, dir}, {hs_susp, 3'h0, wr}, "pin out");
			note(4, 2, 7'h07, {4'h0, (dir & wr) | (~dir & gdrv)}, "general_io_rd");
			note(4, 3, 7'h03, {5'h0, ~dlow, ~clow}, "mgmt pins");
			note(4, 6, 7'h01, {6'h0, swp}, "role_swap_request");
			repeat (4) @(negedge sys_clk);
		end
		boot(3'h1);
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			a0h = i[0] ? lf[6:0] | 7'h01 : 7'h00;
			a0s = i[1] ? lf[13:7] | 7'h01 : 7'h00;
			a1h = i[1] ? lf[20:14] | 7'h01 : 7'h00;
			a1s = i[0] ? lf[27:21] | 7'h01 : 7'h00;
			swp = ~swp;
			note(1, 1, 7'h03, {5'h0, {2{i[0] | i[1]}}}, "host kind oe");
			note(1, 0, {5'h0, {2{i[0] | i[1]}}}, {5'h0, ~i[0], ~i[1]}, "host kind");
			note(4, 0, 7'h44, {swp, 3'h0, ~swp, 2'h0}, "swap state pair");
			note(4, 1, 7'h64, 7'h44, "swap pin oe");
			note(4, 6, 7'h01, {6'h0, swp}, "role_swap_request");
			repeat (4) @(negedge sys_clk);
		end
		// codes in this block leave pins 1-3, 6 and 7 floating
		for (int c = 2; c < 6; c++) begin
			logic m;
			boot(c[2:0]);
			m = (c != 3 && c != 4);
			note(1, 1, 7'h7F, {2'h0, clow & m, dlow & m, 3'h0}, "unused cfg pin oe");
			note(1, 3, 7'h03, {5'h0, ~(dlow & m), ~(clow & m)}, "unused cfg mgmt pins");
			note(1, 6, 7'h01, 7'h00, "unused cfg role_swap_request");
			repeat (2) @(negedge sys_clk);
		end
		// let the checker take the last notes before the verdict
		repeat (2) @(negedge sys_clk);
		print_verdict();
	end
	initial begin
		#(600 * 100);
		n_fail++;
		print_verdict();
	end
endmodule : tb_spm_pin_mux
`default_nettype wire
